//--- shared/fcl_pkg.sv
// Package with fuse offsets, field layouts and timing constants.
package fcl_pkg;
  // Fuse byte indices; the byte address is four times the index.
  localparam logic [3:0] IDX_BROWNOUT   = 4'h1;
  localparam logic [3:0] IDX_OSCILLATOR = 4'h2;
  localparam logic [3:0] IDX_TIMCFG     = 4'h4;
  localparam logic [3:0] IDX_SYS0       = 4'h5;
  localparam logic [3:0] IDX_SYS1       = 4'h6;
  localparam logic [3:0] IDX_APP_END    = 4'h7;
  localparam logic [3:0] IDX_BOOT_END   = 4'h8;
  localparam logic [3:0] IDX_LOCK    = 4'hA;
  localparam logic [3:0] IDX_LAST    = 4'hA;
  // Own status and control registers on the bus.
  localparam logic [11:0] ADDR_STATUS = 12'h040;
  localparam logic [11:0] ADDR_CTRL   = 12'h044;
  localparam logic [11:0] ADDR_CAL16  = 12'h048;
  localparam logic [11:0] ADDR_CAL20  = 12'h04C;
  // Reset values of fuse images where a reset value is defined.
  localparam logic [7:0] RST_SYS0 = 8'hC4;
  localparam logic [7:0] RST_OSC  = 8'h02;
  localparam logic [7:0] RST_SYS1 = 8'h07;
  // Field positions.
  localparam int OSC_LOCK_BIT  = 7;
  localparam int SYS0_EE_KEEP  = 0;
  localparam logic [7:0] LOCK_OPEN = 8'hC5;
  localparam logic [1:0] FREQ_16M = 2'h1;
  localparam logic [1:0] FREQ_20M = 2'h2;
  localparam logic [1:0] PIN_GPIO = 2'h0;
  localparam logic [1:0] PIN_DBG  = 2'h1;
  localparam logic [1:0] PIN_RST  = 2'h2;
  localparam logic [1:0] CRC_NONE = 2'h3;
  localparam logic [1:0] BOD_RSVD = 2'h3;
  // Timing.
  localparam int HOLDOFF_SLOW_CYCLES = 768;
  localparam int CLK_KHZ             = 40000;
  localparam int STARTUP_UNIT_MS     = 1;
  localparam int MS_CYCLES = STARTUP_UNIT_MS * CLK_KHZ;
  typedef enum logic [1:0] {
    FCL_IDLE = 2'b00,
    FCL_LOAD = 2'b01,
    FCL_WAIT = 2'b10,
    FCL_DONE = 2'b11
  } fcl_state_e;
endpackage

//--- design/fcl_holdoff.sv
// Counts slow oscillator ticks to hold off the shared pin driver.
`timescale 1ns/10ps
module fcl_holdoff #(
  parameter int COUNT = fcl_pkg::HOLDOFF_SLOW_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic start_in,
  input  wire logic slow_tick_in,
  output logic      busy_out
);
  import fcl_pkg::*;
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;

  // Reload on every system reset release; count down on slow ticks.
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (start_in)
      cnt_nxt = 11'(COUNT);
    else if (slow_tick_in && cnt_r != 11'h000)
      cnt_nxt = cnt_r - 11'h001;
  end

  // Reset loads the full count so the driver stays off from the start.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      cnt_r <= 11'(COUNT);
    else
      cnt_r <= cnt_nxt;
  end

  assign busy_out = (cnt_r != 11'h000);
endmodule

//--- design/fcl_startup.sv
// Start-up delay timer: 2^(code-1) milliseconds, zero for code 0.
`timescale 1ns/10ps
module fcl_startup #(
  parameter int MS_CYC = fcl_pkg::MS_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       start_in,
  input  wire logic [2:0] code_in,
  output logic            done_out
);
  import fcl_pkg::*;
  logic [15:0] cyc_r;
  logic [15:0] cyc_nxt;
  logic [6:0]  ms_r;
  logic [6:0]  ms_nxt;
  logic        run_r;
  logic        run_nxt;

  // A millisecond prescaler feeds a millisecond down counter.
  always_comb
  begin
    cyc_nxt = cyc_r;
    ms_nxt  = ms_r;
    run_nxt = run_r;
    if (start_in)
    begin
      cyc_nxt = 16'(MS_CYC - 1);
      ms_nxt  = (code_in == 3'h0) ? 7'h00 : 7'(7'h01 << (code_in - 3'h1));
      run_nxt = (code_in != 3'h0);
    end
    else if (run_r)
    begin
      if (cyc_r == 16'h0000)
      begin
        cyc_nxt = 16'(MS_CYC - 1);
        ms_nxt  = ms_r - 7'h01;
        if (ms_r == 7'h01)
          run_nxt = 1'b0;
      end
      else
        cyc_nxt = cyc_r - 16'h0001;
    end
  end

  // Registers only.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      cyc_r <= 16'h0000;
      ms_r  <= 7'h00;
      run_r <= 1'b0;
    end
    else
    begin
      cyc_r <= cyc_nxt;
      ms_r  <= ms_nxt;
      run_r <= run_nxt;
    end
  end

  assign done_out = !run_r && !start_in;
endmodule

//--- design/fcl_loader.sv
// Fuse loader: reads fuse bytes at reset and drives configuration fields.
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
module fcl_loader #(
  parameter int MS_CYC  = fcl_pkg::MS_CYCLES,
  parameter int HOLDOFF = fcl_pkg::HOLDOFF_SLOW_CYCLES
) (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RESET_IN,
  input  wire logic        POR_IN,
  input  wire logic        SLOW_OSC_IN,
  output logic [3:0]       FUSE_ADDR_OUT,
  input  wire logic [7:0]  FUSE_DATA_IN,
  input  wire logic [7:0]  CAL16_IN,
  input  wire logic [7:0]  CAL20_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  output logic [1:0]       BOD_SLEEP_OUT,
  output logic [7:0]       BOD_CFG_OUT,
  output logic             OSC_CAL_LOCK_OUT,
  output logic             OSC_20M_SEL_OUT,
  output logic [7:0]       OSC_CAL_OUT,
  output logic [7:0]       TIMER_FAULT_CTRL_OUT,
  output logic [3:0]       COMPARE_PIN_EN_OUT,
  output logic [3:0]       COMPARE_DEFAULT_OUT,
  output logic [1:0]       CRC_SRC_OUT,
  output logic [1:0]       RST_PIN_FUNC_OUT,
  output logic             PIN_DRIVER_EN_OUT,
  output logic             EEPROM_KEEP_OUT,
  output logic [15:0]      APP_END_ADDR_OUT,
  output logic [15:0]      BOOT_END_ADDR_OUT,
  output logic             DEVICE_LOCKED_OUT,
  output logic             DEBUG_BUS_EN_OUT,
  output logic             CPU_RUN_OUT
);
  import fcl_pkg::*;

  fcl_state_e state_r;
  fcl_state_e state_nxt;
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  logic       por_r;
  logic       por_nxt;
  logic [7:0] bod_r;
  logic [7:0] bod_nxt;
  logic [7:0] osc_r;
  logic [7:0] osc_nxt;
  logic [7:0] tim_r;
  logic [7:0] tim_nxt;
  logic [7:0] sys0_r;
  logic [7:0] sys0_nxt;
  logic [7:0] sys1_r;
  logic [7:0] sys1_nxt;
  logic [7:0] app_r;
  logic [7:0] app_nxt;
  logic [7:0] boot_r;
  logic [7:0] boot_nxt;
  logic [7:0] lock_r;
  logic [7:0] lock_nxt;
  logic       sd_start;
  logic       sd_done;
  logic       slow_s1_r;
  logic       slow_s2_r;
  logic       slow_s3_r;
  logic       slow_tick;
  logic       hold_busy;
  logic       rel_r;
  logic       wr_ok;

  // Combined byte-to-field decode used for both fields.
  function automatic logic [15:0] blk_addr(input logic [7:0] b);
    blk_addr = {b, 8'h00};
  endfunction

  // The slow oscillator is asynchronous, so it passes two flops first.
  always_ff @(posedge CORE_CLK_IN)
  begin
    slow_s1_r <= SLOW_OSC_IN;
    slow_s2_r <= slow_s1_r;
    slow_s3_r <= slow_s2_r;
  end
  assign slow_tick = slow_s2_r & ~slow_s3_r;

  // Loader sequence: walk fuse indices, wait start-up delay, release CPU.
  always_comb
  begin
    state_nxt  = state_r;
    idx_nxt    = idx_r;
    por_nxt    = por_r;
    bod_nxt    = bod_r;
    osc_nxt    = osc_r;
    tim_nxt    = tim_r;
    sys0_nxt   = sys0_r;
    sys1_nxt   = sys1_r;
    app_nxt    = app_r;
    boot_nxt   = boot_r;
    lock_nxt   = lock_r;
    sd_start   = 1'b0;
    unique case (state_r)
      FCL_IDLE:
      begin
        idx_nxt   = IDX_BROWNOUT;
        state_nxt = FCL_LOAD;
      end
      FCL_LOAD:
      begin
        // Fuse data belongs to the address issued last cycle.
        unique case (idx_r)
          IDX_BROWNOUT:   if (por_r) bod_nxt = FUSE_DATA_IN;
          IDX_OSCILLATOR: osc_nxt  = FUSE_DATA_IN;
          IDX_TIMCFG:     if (por_r) tim_nxt = FUSE_DATA_IN;
          IDX_SYS0:       sys0_nxt = FUSE_DATA_IN;
          IDX_SYS1:       sys1_nxt = FUSE_DATA_IN;
          IDX_APP_END:    app_nxt  = FUSE_DATA_IN;
          IDX_BOOT_END:   boot_nxt = FUSE_DATA_IN;
          IDX_LOCK:    lock_nxt = FUSE_DATA_IN;
          default:     idx_nxt  = idx_r;
        endcase
        if (idx_r == IDX_LAST)
        begin
          state_nxt = FCL_WAIT;
          sd_start  = 1'b1;
        end
        else
          idx_nxt = idx_r + 4'h1;
      end
      FCL_WAIT:
        if (sd_done)
        begin
          state_nxt = FCL_DONE;
          por_nxt   = 1'b0;
        end
      FCL_DONE:
        state_nxt = FCL_DONE;
    endcase
  end

  // A power-on mark survives warm resets so POR-only fields stay put.
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RESET_IN)
    begin
      state_r <= FCL_IDLE;
      idx_r   <= IDX_BROWNOUT;
      osc_r   <= RST_OSC;
      sys0_r  <= RST_SYS0;
      sys1_r  <= RST_SYS1;
      app_r   <= 8'h00;
      boot_r  <= 8'h00;
      lock_r  <= 8'h00;
      rel_r   <= 1'b1;
      if (POR_IN)
      begin
        por_r <= 1'b1;
        bod_r <= 8'h00;
        tim_r <= 8'h00;
      end
    end
    else
    begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      por_r   <= por_nxt;
      bod_r   <= bod_nxt;
      osc_r   <= osc_nxt;
      tim_r   <= tim_nxt;
      sys0_r  <= sys0_nxt;
      sys1_r  <= sys1_nxt;
      app_r   <= app_nxt;
      boot_r  <= boot_nxt;
      lock_r  <= lock_nxt;
      rel_r   <= 1'b0;
    end
  end

  // Reset must keep the processor stalled on the very next edge.
  property p_run_held_in_reset;
    @(posedge CORE_CLK_IN)
    RESET_IN |=> !CPU_RUN_OUT;
  endproperty
  a_run_held_in_reset: assert property (p_run_held_in_reset)
    else $error("Processor released while reset was held.");

  // The last fuse byte hands over to the start-up delay, never to run.
  property p_load_ends_in_wait;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (state_r == FCL_LOAD && idx_r == IDX_LAST) |=> (state_r == FCL_WAIT);
  endproperty
  a_load_ends_in_wait: assert property (p_load_ends_in_wait)
    else $error("Loader did not enter the start-up wait.");

  // Oscillator image equals the byte returned for its index.
  property p_osc_image_loaded;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (state_r == FCL_LOAD && idx_r == IDX_OSCILLATOR)
      |=> (osc_r == $past(FUSE_DATA_IN));
  endproperty
  a_osc_image_loaded: assert property (p_osc_image_loaded)
    else $error("Oscillator image differs from its fuse byte.");

  // System image feeds the pin function and scan source fields.
  property p_sys0_image_loaded;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (state_r == FCL_LOAD && idx_r == IDX_SYS0)
      |=> (sys0_r == $past(FUSE_DATA_IN));
  endproperty
  a_sys0_image_loaded: assert property (p_sys0_image_loaded)
    else $error("System image differs from its fuse byte.");

  // The lock image is reloaded on every reset, warm or cold.
  property p_lock_image_loaded;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (state_r == FCL_LOAD && idx_r == IDX_LOCK)
      |=> (lock_r == $past(FUSE_DATA_IN));
  endproperty
  a_lock_image_loaded: assert property (p_lock_image_loaded)
    else $error("Lock image differs from its fuse byte.");

  // A warm reset must not disturb the brown-out image.
  property p_bod_kept_warm;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (state_r == FCL_LOAD && idx_r == IDX_BROWNOUT && !por_r)
      |=> $stable(bod_r);
  endproperty
  a_bod_kept_warm: assert property (p_bod_kept_warm)
    else $error("Brown-out image changed on a warm reset.");

  // A warm reset must not disturb the compare output settings.
  property p_tim_kept_warm;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (state_r == FCL_LOAD && idx_r == IDX_TIMCFG && !por_r)
      |=> $stable(tim_r);
  endproperty
  a_tim_kept_warm: assert property (p_tim_kept_warm)
    else $error("Timer image changed on a warm reset.");

  assign FUSE_ADDR_OUT = idx_nxt;

  fcl_startup #(
    .MS_CYC   (MS_CYC)
  ) fcl_startup_inst (
    .clk_in   (CORE_CLK_IN),
    .reset_in (RESET_IN),
    .start_in (sd_start),
    .code_in  (sys1_r[2:0]),
    .done_out (sd_done)
  );

  // Hold-off restarts at each reset release, whatever the pin function.
  fcl_holdoff #(
    .COUNT        (HOLDOFF)
  ) fcl_holdoff_inst (
    .clk_in       (CORE_CLK_IN),
    .reset_in     (RESET_IN),
    .start_in     (rel_r),
    .slow_tick_in (slow_tick),
    .busy_out     (hold_busy)
  );

  // Decoded configuration fields.
  assign BOD_SLEEP_OUT        = bod_r[1:0];
  assign BOD_CFG_OUT          = bod_r;
  assign OSC_CAL_LOCK_OUT     = osc_r[OSC_LOCK_BIT];
  assign OSC_20M_SEL_OUT      = (osc_r[1:0] == FREQ_20M);
  // Reserved frequency codes fall back to the 20 MHz calibration.
  assign OSC_CAL_OUT = (osc_r[1:0] == FREQ_16M) ? CAL16_IN : CAL20_IN;
  assign TIMER_FAULT_CTRL_OUT = tim_r;
  assign COMPARE_PIN_EN_OUT   = tim_r[7:4];
  assign COMPARE_DEFAULT_OUT  = tim_r[3:0];
  assign CRC_SRC_OUT          = sys0_r[7:6];
  assign RST_PIN_FUNC_OUT     = sys0_r[3:2];
  assign PIN_DRIVER_EN_OUT = (sys0_r[3:2] == PIN_GPIO) && !hold_busy
                             && (state_r == FCL_DONE);
  assign DEVICE_LOCKED_OUT    = (lock_r != LOCK_OPEN);
  assign EEPROM_KEEP_OUT = sys0_r[SYS0_EE_KEEP] && !DEVICE_LOCKED_OUT;
  assign DEBUG_BUS_EN_OUT     = !DEVICE_LOCKED_OUT;
  assign APP_END_ADDR_OUT     = blk_addr(app_r);
  assign BOOT_END_ADDR_OUT    = blk_addr(boot_r);
  assign CPU_RUN_OUT          = (state_r == FCL_DONE);

  // No pin drive during the hold-off or when the pin is not GPIO.
  property p_driver_held_off;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
    (hold_busy || RST_PIN_FUNC_OUT != PIN_GPIO) |-> !PIN_DRIVER_EN_OUT;
  endproperty
  a_driver_held_off: assert property (p_driver_held_off)
    else $error("Shared pin driven outside its allowed window.");

  // A locked part may never keep the EEPROM through a chip erase.
  property p_erase_when_locked;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
    DEVICE_LOCKED_OUT |-> !EEPROM_KEEP_OUT;
  endproperty
  a_erase_when_locked: assert property (p_erase_when_locked)
    else $error("EEPROM kept on erase while locked.");

  // APB slave: zero wait states, writes accepted only at the lock image, which they leave unchanged.
  assign PREADY_OUT  = 1'b1;
  assign wr_ok       = PADDR_IN[11:2] == {6'h00, IDX_LOCK};
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && PWRITE_IN && !wr_ok;

  // Read data registered at the setup edge and held afterwards.
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RESET_IN)
      PRDATA_OUT <= 32'h0000_0000;
    else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
    begin
      PRDATA_OUT <= 32'h0000_0000;
      unique case (PADDR_IN)
        {6'h00, IDX_BROWNOUT, 2'b00}:   PRDATA_OUT[7:0] <= bod_r;
        {6'h00, IDX_OSCILLATOR, 2'b00}: PRDATA_OUT[7:0] <= osc_r;
        {6'h00, IDX_TIMCFG, 2'b00}:     PRDATA_OUT[7:0] <= tim_r;
        {6'h00, IDX_SYS0, 2'b00}:       PRDATA_OUT[7:0] <= sys0_r;
        {6'h00, IDX_SYS1, 2'b00}:       PRDATA_OUT[7:0] <= sys1_r;
        {6'h00, IDX_APP_END, 2'b00}:    PRDATA_OUT[7:0] <= app_r;
        {6'h00, IDX_BOOT_END, 2'b00}:   PRDATA_OUT[7:0] <= boot_r;
        {6'h00, IDX_LOCK, 2'b00}:    PRDATA_OUT[7:0] <= lock_r;
        ADDR_STATUS: PRDATA_OUT[3:0] <= {hold_busy, DEVICE_LOCKED_OUT,
                                         por_r, CPU_RUN_OUT};
        ADDR_CAL16:  PRDATA_OUT[7:0] <= CAL16_IN;
        ADDR_CAL20:  PRDATA_OUT[7:0] <= CAL20_IN;
        default:     PRDATA_OUT <= 32'h0000_0000;
      endcase
    end
  end
endmodule

//--- tb/fcl_fuse_model.sv
// Behavioural fuse array that answers the loader's byte index.
`timescale 1ns/10ps
module fcl_fuse_model (
  input  wire logic       clk_in,
  input  wire logic [3:0] addr_in,
  output logic      [7:0] data_out
);
  logic [7:0] mem [0:15];
  // The byte comes one cycle after the index, as the loader expects.
  always @(posedge clk_in)
  begin
    data_out <= mem[addr_in];
  end
endmodule

//--- tb/fcl_loader_tb_top.sv
// Self-checking bench for the fuse configuration loader.
`timescale 1ns/10ps
module fcl_loader_tb_top;
  import fcl_pkg::*;
  localparam int MS = 10;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        por = 1'b1;
  logic        slow = 1'b0;
  logic [4:0]  scnt = 5'h00;
  logic [3:0]  faddr;
  logic [7:0]  fdata;
  logic [7:0]  cal16 = 8'h00;
  logic [7:0]  cal20 = 8'h00;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, lk_o, osc_lk, sel20, drv, keep, dbg, run;
  logic [1:0]  bsl, crc, pfn;
  logic [7:0]  bcfg, ocal, tfc, eb, et, o, s;
  logic [3:0]  cen, cdf;
  logic [15:0] app, boot;
  logic [31:0] d;
  logic        e, lk;
  int          seed = 82;
  int          mismatches = 0;
  int          total_checks = 0;
  int          n;
  int          dl;

  fcl_loader #(.MS_CYC(MS), .HOLDOFF(4)) fcl_loader_inst (
    .CORE_CLK_IN(clk), .RESET_IN(rst), .POR_IN(por), .SLOW_OSC_IN(slow),
    .FUSE_ADDR_OUT(faddr), .FUSE_DATA_IN(fdata), .CAL16_IN(cal16),
    .CAL20_IN(cal20), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(4'hF),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .BOD_SLEEP_OUT(bsl), .BOD_CFG_OUT(bcfg), .OSC_CAL_LOCK_OUT(osc_lk),
    .OSC_20M_SEL_OUT(sel20), .OSC_CAL_OUT(ocal),
    .TIMER_FAULT_CTRL_OUT(tfc), .COMPARE_PIN_EN_OUT(cen),
    .COMPARE_DEFAULT_OUT(cdf), .CRC_SRC_OUT(crc),
    .RST_PIN_FUNC_OUT(pfn),
    .PIN_DRIVER_EN_OUT(drv), .EEPROM_KEEP_OUT(keep),
    .APP_END_ADDR_OUT(app), .BOOT_END_ADDR_OUT(boot),
    .DEVICE_LOCKED_OUT(lk_o), .DEBUG_BUS_EN_OUT(dbg), .CPU_RUN_OUT(run));
  fcl_fuse_model fcl_fuse_model_inst (
    .clk_in(clk), .addr_in(faddr), .data_out(fdata));

  // Free-running core clock at 40 MHz.
  always #12.5 clk = ~clk;

  // Slow oscillator as data, far slower than the core so ticks are visible.
  always @(posedge clk)
  begin
    scnt <= (scnt == 5'h13) ? 5'h00 : scnt + 5'h01;
    if (scnt == 5'h13)
      slow <= ~slow;
  end

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] g);
    total_checks++;
    if (g !== ex)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a);
    int k;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= $random(seed);
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
      mismatches++;
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // Watchdog well beyond the longest start-up sweep.
  initial
  begin
    #2000000;
    mismatches++;
    finish_test();
  end

  // Eight resets, each with a fresh random image and one start-up code.
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      for (int j = 0; j < 16; j++)
        fcl_fuse_model_inst.mem[j] = $random(seed);
      fcl_fuse_model_inst.mem[6] = 8'(i);
      fcl_fuse_model_inst.mem[5][3:2] = 2'(i);
      if (i % 2 == 0)
      begin
        fcl_fuse_model_inst.mem[10] = LOCK_OPEN;
        fcl_fuse_model_inst.mem[5][0] = 1'b1;
      end
      o = fcl_fuse_model_inst.mem[2];
      s = fcl_fuse_model_inst.mem[5];
      lk = fcl_fuse_model_inst.mem[10] != LOCK_OPEN;
      cal16 <= $random(seed);
      cal20 <= $random(seed);
      por <= (i != 5);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      chk("run_in_reset", 0, run);
      chk("crc_in_reset", 3, crc);
      if (por)
      begin
        eb = fcl_fuse_model_inst.mem[1];
        et = fcl_fuse_model_inst.mem[4];
      end
      rst <= 1'b0;
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (run !== 1'b1 && n < 1000);
      dl = (i == 0) ? 0 : (1 << (i - 1)) * MS;
      chk("startup", 1, n >= dl && n <= dl + 20);
      if (i < 3)
        chk("drv_holdoff", 0, drv);
      repeat (320) @(posedge clk);
      chk("drv_after", s[3:2] == PIN_GPIO, drv);
      chk("bod_sleep", eb[1:0], bsl);
      chk("bod_cfg", eb, bcfg);
      chk("osc_lock", o[7], osc_lk);
      chk("osc_cal", o[1:0] == FREQ_16M ? cal16 : cal20, ocal);
      chk("sel20", o[1:0] == FREQ_20M, sel20);
      chk("fault_ctrl", et, tfc);
      chk("cmp_en", et[7:4], cen);
      chk("cmp_def", et[3:0], cdf);
      chk("crc", s[7:6], crc);
      chk("pin_func", s[3:2], pfn);
      chk("ee_keep", s[0] & !lk, keep);
      chk("app", {fcl_fuse_model_inst.mem[7], 8'h00}, app);
      chk("boot", {fcl_fuse_model_inst.mem[8], 8'h00}, boot);
      chk("locked", lk, lk_o);
      chk("dbg_bus", !lk, dbg);
      for (int j = 2; j <= 10; j++)
      begin
        if (j != 3 && j != 9)
        begin
          apb(1'b0, 12'(j * 4));
          chk("fuse_rd", j == 4 ? et : fcl_fuse_model_inst.mem[j], d);
        end
      end
      apb(1'b0, ADDR_STATUS);
      chk("status", {1'b0, lk, 1'b0, 1'b1}, d);
      apb(1'b0, ADDR_CAL16);
      chk("cal16_rd", cal16, d);
      apb(1'b0, ADDR_CAL20);
      chk("cal20_rd", cal20, d);
      apb(1'b0, 12'h3FC);
      chk("unmapped", 0, d);
      apb(1'b1, 12'(IDX_SYS0 * 4));
      chk("wr_err", 1, e);
      apb(1'b1, 12'(IDX_LOCK * 4));
      chk("lock_wr_err", 0, e);
      apb(1'b0, 12'(IDX_LOCK * 4));
      chk("lock_kept", fcl_fuse_model_inst.mem[10], d);
      $display("test %0d done", i);
    end
    finish_test();
  end
endmodule
